/* File: rtl/pgw_pkg.sv */
package pgw_pkg;
    localparam int          PGW_W        = 8;
    localparam int          PGW_AW       = 4;
    // register offsets on the plain register port
    localparam logic [3:0]  PGW_OFS_DATA = 4'h0;
    localparam logic [3:0]  PGW_OFS_DIR  = 4'h1;
    localparam logic [3:0]  PGW_OFS_PUP  = 4'h2;
    localparam logic [3:0]  PGW_OFS_FSEL = 4'h3;
    localparam logic [3:0]  PGW_OFS_PIN  = 4'h4;
    localparam logic [3:0]  PGW_OFS_WAKE = 4'h5;
    // reset values and fixed read answers
    localparam logic [7:0]  PGW_RST_VAL  = 8'h00;
    localparam logic [7:0]  PGW_DIR_RD   = 8'hFF;
    localparam logic [7:0]  PGW_UNMAP_RD = 8'h00;
endpackage

/* File: rtl/pgw_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// two-stage synchroniser for pin levels
module pgw_sync
    import pgw_pkg::*;
(
    input  wire logic             i_sys_clk,
    input  wire logic             i_nrst,
    input  wire logic [PGW_W-1:0] i_async,
    output logic      [PGW_W-1:0] o_sync
);
    logic [PGW_W-1:0] meta_q;

    // first stage feeds only the second
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            meta_q <= PGW_RST_VAL;
            o_sync <= PGW_RST_VAL;
        end else begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end
endmodule
`default_nettype wire

/* File: rtl/pgw_port.sv */
// Function
// - eight-bit output data latch, one bit per pin 7..0
// - output pin: data read returns latched bit, not pin level
// - input pin: data read returns synchronised live pin level
// - direction bit 1 makes pin output, 0 makes it input
// - direction and data act only while pin is general I/O; direction still selects the data read view and, in wake mode, gates pull-up
// - direction register is write-only and reads all ones
// - reset clears direction, data, pull-up and function select
// - input pin: pull-up bit 1 enables pull-up, 0 disables
// - function select is eight-bit read/write, one bit per pin
// - function select 0 is general I/O, 1 active-low wake input
// - segment ownership overrides general I/O and wake selection
//
// Local design decisions: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module pgw_port
    import pgw_pkg::*;
(
    input  wire logic              i_sys_clk,
    input  wire logic              i_nrst,
    input  wire logic [PGW_AW-1:0] i_addr,
    input  wire logic [PGW_W-1:0]  i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    output logic      [PGW_W-1:0]  o_rdata,
    input  wire logic [PGW_W-1:0]  i_pin,
    output logic      [PGW_W-1:0]  o_pin,
    output logic      [PGW_W-1:0]  o_pin_oe,
    output logic      [PGW_W-1:0]  o_pullup_en,
    input  wire logic [PGW_W-1:0]  i_segment_pin_group_select,
    output logic      [PGW_W-1:0]  o_wake_n
);
    logic [PGW_W-1:0] port_output_data_q;
    logic [PGW_W-1:0] port_direction_control_q;
    logic [PGW_W-1:0] port_pullup_control_q;
    logic [PGW_W-1:0] port_function_select_q;
    logic [PGW_W-1:0] pin_sync;
    logic [PGW_W-1:0] seg_sync;
    logic [PGW_W-1:0] gpio_own;
    logic [PGW_W-1:0] wake_own;
    logic [PGW_W-1:0] drive;
    logic [PGW_W-1:0] data_view;
    logic [PGW_W-1:0] rdata_d;

    // address match helper used by both write and read paths
    function automatic logic hit(input logic [PGW_AW-1:0] a,
                                 input logic [PGW_AW-1:0] ofs);
        hit = (a == ofs);
    endfunction

    // pin levels and segment claims come from outside this clock
    pgw_sync u_pin_sync (
        .i_sys_clk (i_sys_clk),
        .i_nrst    (i_nrst),
        .i_async   (i_pin),
        .o_sync    (pin_sync)
    );

    pgw_sync u_seg_sync (
        .i_sys_clk (i_sys_clk),
        .i_nrst    (i_nrst),
        .i_async   (i_segment_pin_group_select),
        .o_sync    (seg_sync)
    );

    // data latch
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            port_output_data_q <= PGW_RST_VAL;
        end else if (i_wr && hit(i_addr, PGW_OFS_DATA)) begin
            port_output_data_q <= i_wdata;
        end
    end

    // direction control, never readable
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            port_direction_control_q <= PGW_RST_VAL;
        end else if (i_wr && hit(i_addr, PGW_OFS_DIR)) begin
            port_direction_control_q <= i_wdata;
        end
    end

    // pull-up control
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            port_pullup_control_q <= PGW_RST_VAL;
        end else if (i_wr && hit(i_addr, PGW_OFS_PUP)) begin
            port_pullup_control_q <= i_wdata;
        end
    end

    // function select
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            port_function_select_q <= PGW_RST_VAL;
        end else if (i_wr && hit(i_addr, PGW_OFS_FSEL)) begin
            port_function_select_q <= i_wdata;
        end
    end

    // per-pin ownership: segment first, then wake, else general I/O
    genvar g;
    generate
        for (g = 0; g < PGW_W; g++) begin : g_pin
            assign wake_own[g]  = !seg_sync[g] && port_function_select_q[g];
            assign gpio_own[g]  = !seg_sync[g] && !port_function_select_q[g];
            assign drive[g]     = gpio_own[g] && port_direction_control_q[g];
            assign data_view[g] = port_direction_control_q[g] ? port_output_data_q[g]
                                                              : pin_sync[g];
        end
    endgenerate

    // pad controls from flip-flops
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_pin       <= PGW_RST_VAL;
            o_pin_oe    <= PGW_RST_VAL;
            o_pullup_en <= PGW_RST_VAL;
        end else begin
            o_pin       <= port_output_data_q & drive;
            o_pin_oe    <= drive;
            o_pullup_en <= port_pullup_control_q & ~port_direction_control_q
                           & ~seg_sync;
        end
    end

    // active-low wake requests, idle high
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_wake_n <= PGW_DIR_RD;
        end else begin
            o_wake_n <= ~(wake_own & ~pin_sync);
        end
    end

    // read mux
    always_comb begin
        rdata_d = PGW_UNMAP_RD;
        if (i_rd) begin
            unique case (1'b1)
                hit(i_addr, PGW_OFS_DATA): rdata_d = data_view;
                hit(i_addr, PGW_OFS_DIR):  rdata_d = PGW_DIR_RD;
                hit(i_addr, PGW_OFS_PUP):  rdata_d = port_pullup_control_q;
                hit(i_addr, PGW_OFS_FSEL): rdata_d = port_function_select_q;
                hit(i_addr, PGW_OFS_PIN):  rdata_d = pin_sync;
                hit(i_addr, PGW_OFS_WAKE): rdata_d = ~o_wake_n;
                default:                   rdata_d = PGW_UNMAP_RD;
            endcase
        end
    end

    // read data one cycle after strobe, zero otherwise
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rdata <= PGW_UNMAP_RD;
        end else begin
            o_rdata <= rdata_d;
        end
    end
endmodule
`default_nettype wire

/* File: test/pgw_pad_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pgw_pad_model (
    input  wire logic       i_clk,
    input  wire logic [7:0] i_drv, i_oe, i_pu, i_ext, i_xen,
    output logic      [7:0] o_pad
);
    logic [7:0] flt_q;
    // a floating, unpulled line wanders every cycle
    initial flt_q = 8'h55;
    always @(posedge i_clk) flt_q <= ~flt_q;
    // board drive wins, so contention shows what the port reads
    assign o_pad = (i_xen & i_ext) | (~i_xen & i_oe & i_drv) | (~i_xen & ~i_oe & (i_pu | flt_q));
endmodule
`default_nettype wire

/* File: test/pgw_port_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module pgw_port_checker
    import pgw_pkg::*;
(
    input wire logic       i_sys_clk, i_nrst, i_wr, i_rd,
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata, o_rdata, o_pin_oe, o_pullup_en, o_wake_n,
    input wire logic [7:0] i_segment_pin_group_select
);
    logic [15:0] w, r;
    // one-hot strobes by offset
    assign w = 16'(i_wr) << i_addr;
    assign r = 16'(i_rd) << i_addr;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);
    property p_dir; r[PGW_OFS_DIR] |=> o_rdata == PGW_DIR_RD; endproperty
    a_dir: assert property (p_dir) else $error("dir");
    property p_dat; w[PGW_OFS_DATA] ##1 r[PGW_OFS_DATA] && &o_pin_oe
        |=> o_rdata == $past(i_wdata, 2); endproperty
    a_dat: assert property (p_dat) else $error("dat");
    property p_fsl; w[PGW_OFS_FSEL] ##1 r[PGW_OFS_FSEL] |=> o_rdata == $past(i_wdata, 2); endproperty
    a_fsl: assert property (p_fsl) else $error("fsel");
    property p_oe; w[PGW_OFS_DIR] && !i_wdata ##1 !w[PGW_OFS_DIR] |=> !o_pin_oe; endproperty
    a_oe: assert property (p_oe) else $error("oe");
    property p_pu; w[PGW_OFS_PUP] && !i_wdata ##1 !w[PGW_OFS_PUP] |=> !o_pullup_en; endproperty
    a_pu: assert property (p_pu) else $error("pu");
    property p_wk; w[PGW_OFS_FSEL] && !i_wdata ##1 !w[PGW_OFS_FSEL] |=> &o_wake_n; endproperty
    a_wk: assert property (p_wk) else $error("wake");
    property p_pux; !(o_pin_oe & o_pullup_en); endproperty
    a_pux: assert property (p_pux) else $error("pux");
    property p_seg; &i_segment_pin_group_select [*4] |=> !o_pin_oe && &o_wake_n; endproperty
    a_seg: assert property (p_seg) else $error("seg");
endmodule
bind pgw_port pgw_port_checker u_chk (.i_sys_clk, .i_nrst, .i_wr, .i_rd, .i_addr, .i_wdata,
    .o_rdata, .o_pin_oe, .o_pullup_en, .o_wake_n, .i_segment_pin_group_select);
`default_nettype wire

/* File: test/pgw_port_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module pgw_port_tb;
    import pgw_pkg::*;
    logic        clk = 0, nrst = 0, wr = 0, rd = 0, rdv = 0;
    logic [3:0]  addr = 0;
    logic [7:0]  wd = 0, seg = 0, ext = 0, xen = 0, rdata, pin, drv, oe, pu, wake, q[$];
    logic [31:0] seed = 32'h94FBF685;
    int          failures = 0, checks = 0;
    always #50 clk = ~clk;
    pgw_port u_dut (.i_sys_clk(clk), .i_nrst(nrst), .i_addr(addr), .i_wdata(wd), .i_wr(wr),
        .i_rd(rd), .o_rdata(rdata), .i_pin(pin), .o_pin(drv), .o_pin_oe(oe), .o_pullup_en(pu),
        .i_segment_pin_group_select(seg), .o_wake_n(wake));
    pgw_pad_model u_pad (.i_clk(clk), .i_drv(drv), .i_oe(oe), .i_pu(pu), .i_ext(ext),
        .i_xen(xen), .o_pad(pin));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], ^(s & 32'h80200003)};
    endfunction
    task automatic chk(input string nm, input logic [7:0] e, g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // one bus cycle; a read notes its expected answer
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        wr <= w;
        rd <= !w;
        addr <= a;
        wd <= d;
        if (!w) q.push_back(d);
        @(posedge clk);
    endtask
    task automatic idle(input int n);
        wr <= 0;
        rd <= 0;
        repeat (n) @(posedge clk);
        #1;
    endtask
    // read answer stands only in the cycle after the read
    always @(posedge clk) rdv <= rd;
    always @(negedge clk) if (rdv) chk("rdata", q.pop_front(), rdata);
    initial begin
        #100000;
        failures++;
        finish_test();
    end
    initial begin
        repeat (6) @(posedge clk);
        nrst <= 1;
        bus(0, PGW_OFS_FSEL, 8'h00);
        bus(0, PGW_OFS_DIR, 8'hFF);
        xen <= 8'hFF;
        repeat (8) begin
            seed = lfsr(seed);
            ext <= ~seed[7:0];
            bus(1, PGW_OFS_DIR, 8'hFF);
            bus(1, PGW_OFS_DATA, seed[7:0]);
            bus(0, PGW_OFS_DATA, seed[7:0]);
            bus(1, PGW_OFS_DIR, 8'h00);
            bus(1, PGW_OFS_PUP, 8'h00);
            bus(0, PGW_OFS_DATA, ~seed[7:0]);
        end
        xen <= 8'h00;
        bus(1, PGW_OFS_DIR, 8'h0F);
        bus(1, PGW_OFS_PUP, 8'hFF);
        bus(0, PGW_OFS_PUP, 8'hFF);
        idle(3);
        chk("pullup", 8'hF0, pu);
        chk("pin", seed[7:0] & 8'h0F, drv);
        xen <= 8'hFF;
        ext <= 8'h5A;
        bus(1, PGW_OFS_FSEL, 8'hFF);
        bus(0, PGW_OFS_FSEL, 8'hFF);
        idle(4);
        chk("wake", 8'h5A, wake);
        bus(0, PGW_OFS_WAKE, 8'hA5);
        bus(0, PGW_OFS_PIN, 8'h5A);
        seg <= 8'hFF;
        bus(1, PGW_OFS_FSEL, 8'h00);
        bus(1, PGW_OFS_DIR, 8'hFF);
        idle(5);
        chk("oe", 8'h00, oe);
        nrst <= 0;
        idle(1);
        nrst <= 1;
        seg <= 8'h00;
        bus(0, PGW_OFS_PUP, 8'h00);
        idle(2);
        finish_test();
    end
endmodule
`default_nettype wire
